// [cecaf_pkg.sv]
// Constants and carrier types for the CEC enable and address filter block
package cecaf_pkg;

	// Bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [31:0] BASE_ADDR = 32'h4004_0300;

	// Register byte offsets from the base
	localparam logic [7:0] OFF_UNIT_ENABLE = 8'h00;
	localparam logic [7:0] OFF_LOGICAL_ADDRESS_MASK = 8'h04;
	localparam logic [7:0] OFF_SOFT_RESET = 8'h08;
	localparam logic [7:0] OFF_RECEIVE_ENABLE = 8'h0c;
	localparam logic [7:0] OFF_RECEIVE_BUFFER = 8'h10;
	localparam logic [7:0] OFF_RECEIVE_CONTROL_1 = 8'h14;
	localparam logic [7:0] OFF_RECEIVE_CONTROL_2 = 8'h18;
	localparam logic [7:0] OFF_RECEIVE_CONTROL_3 = 8'h1c;
	localparam logic [7:0] OFF_TRANSMIT_ENABLE = 8'h20;
	localparam logic [7:0] OFF_TRANSMIT_BUFFER = 8'h24;
	localparam logic [7:0] OFF_TRANSMIT_CONTROL = 8'h28;
	localparam logic [7:0] OFF_RECEIVE_IRQ_STATUS = 8'h2c;
	localparam logic [7:0] OFF_TRANSMIT_IRQ_STATUS = 8'h30;

	// Field positions
	localparam int EN_MODULE_BIT = 0;
	localparam int EN_IDLE_BIT = 1;
	localparam int UNIT_ENABLE_W = 2;
	localparam int MASK_W = 16;
	localparam int SRST_BIT = 0;
	localparam int RX_ACTIVE_BIT = 0;
	localparam int LADDR_W = 4;
	localparam logic [3:0] BCAST_ADDR = 4'hf;
	localparam int BCAST_MASK_BIT = 15;

	// Values after reset
	localparam logic [1:0] UNIT_ENABLE_RST = 2'h0;
	localparam logic [15:0] MASK_RST = 16'h0000;
	localparam logic [31:0] CTL_RST = 32'h0000_0000;

	// Plain control slots; each reads back its writable bits as written except SLOT_RX_ENABLE, which reads rx_active
	localparam int NCTL = 7;
	localparam logic [2:0] SLOT_RX_ENABLE = 3'h0;
	localparam logic [2:0] SLOT_RX_CTRL1 = 3'h1;
	localparam logic [2:0] SLOT_RX_CTRL2 = 3'h2;
	localparam logic [2:0] SLOT_RX_CTRL3 = 3'h3;
	localparam logic [2:0] SLOT_TX_ENABLE = 3'h4;
	localparam logic [2:0] SLOT_TX_BUFFER = 3'h5;
	localparam logic [2:0] SLOT_TX_CTRL = 3'h6;
	localparam logic [2:0] SLOT_NONE = 3'h7;

	// Writable bits of each slot
	localparam logic [31:0] CTL_WMASK [NCTL] = '{
		32'h0000_0001, 32'h0137_7777, 32'hffff_ffff, 32'hffff_ffff,
		32'h0000_0001, 32'hffff_ffff, 32'hffff_ffff
	};

	// Header seen by the receiver: destination logical address
	typedef struct packed {
		logic valid;
		logic [3:0] dest;
	} cecaf_hdr_s;

	// Address filter verdict
	typedef struct packed {
		logic valid;
		logic hit;
		logic bcast;
		logic ack_low;
	} cecaf_match_s;

	// State reported by the bit engines
	typedef struct packed {
		logic rx_active;
		logic [31:0] rx_buffer;
		logic [31:0] rx_status;
		logic [31:0] tx_status;
	} cecaf_stat_s;

	// Settings handed to the bit engines
	typedef struct packed {
		logic idle_mode_operation;
		logic [15:0] logical_address_mask;
		logic [NCTL-1:0][31:0] ctl;
	} cecaf_cfg_s;

endpackage

// [cecaf_addr_filter.sv]
// Logical address match and acknowledge decision for incoming headers
`timescale 1ns/1ps
module cecaf_addr_filter (
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Control
	input wire logic run_en,
	input wire logic clear,
	input wire logic [15:0] mask,
	// Header in, verdict out
	input cecaf_pkg::cecaf_hdr_s hdr,
	output cecaf_pkg::cecaf_match_s match
);

	cecaf_pkg::cecaf_match_s match_q;
	cecaf_pkg::cecaf_match_s match_d;
	logic is_bcast;
	logic direct_hit;

	assign is_bcast = (hdr.dest == cecaf_pkg::BCAST_ADDR);
	// R6 - any set bit
	assign direct_hit = mask[hdr.dest] & ~is_bcast;

	assign match_d.valid = hdr.valid & run_en & ~clear;
	// R7 - broadcast always received
	assign match_d.hit = direct_hit | is_bcast;
	assign match_d.bcast = is_bcast;
	// R8 - broadcast ack needs bit 15
	assign match_d.ack_low = direct_hit | (is_bcast & mask[cecaf_pkg::BCAST_MASK_BIT]);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			match_q <= '0;
		end else begin
			match_q <= match_d.valid ? match_d : '0;
		end
	end

	assign match = match_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	a_bcast_always_hit: assert property ( // R7
		hdr.valid && run_en && !clear && hdr.dest == 4'hf |=> match.valid && match.hit
	) else $error("broadcast header not received");

	a_bcast_ack_bit: assert property ( // R8
		hdr.valid && run_en && !clear && hdr.dest == 4'hf |=> match.ack_low == $past(mask[15])
	) else $error("broadcast acknowledge does not follow mask bit 15");

	a_direct_mask_hit: assert property ( // R6
		hdr.valid && run_en && !clear && hdr.dest != 4'hf |=> match.hit == $past(mask[hdr.dest])
	) else $error("direct address match does not follow mask");

	c_bcast_ack: cover property (hdr.valid && run_en && hdr.dest == 4'hf && mask[15] ##1 match.ack_low);

endmodule

// [cecaf_top.sv]
// Register front end of the CEC controller: enable, idle control, address mask
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Bit 0 of the unit enable register enables the controller; while clear nothing runs.
// R2 - While disabled only the unit enable register takes writes; writes to the rest are gated off.
// R3 - Disabling the controller leaves every other register's contents unchanged.
// R4 - Bit 1 of the unit enable register keeps the controller running in chip idle mode.
// R5 - One write may set both enable bits and both take effect.
// R6 - The 16-bit mask holds one bit per logical address 0-15; any set address matches.
// R7 - Broadcast messages are received whatever the mask holds.
// R8 - Mask bit 15 makes the controller drive a low acknowledge on broadcasts.
// R9 - Thirteen registers are decoded at byte offsets 0x00 to 0x30 in the documented order.
// R10 - A soft reset re-initialises every register except the unit enable register.
// R11 - Unused upper bits of enable and mask read zero, ignore writes, and reset to zero.
module cecaf_top (
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Power state
	input wire logic chip_idle,
	// Bit engines
	input cecaf_pkg::cecaf_stat_s eng_stat,
	input cecaf_pkg::cecaf_hdr_s hdr,
	output logic run_en,
	output logic soft_reset_pulse,
	output cecaf_pkg::cecaf_cfg_s cfg,
	output cecaf_pkg::cecaf_match_s match
);

	// Map a byte offset to a plain control slot
	function automatic logic [2:0] slot_of(input logic [7:0] a);
		logic [2:0] s;
		s = cecaf_pkg::SLOT_NONE;
		unique case (a)
			cecaf_pkg::OFF_RECEIVE_ENABLE: s = cecaf_pkg::SLOT_RX_ENABLE;
			cecaf_pkg::OFF_RECEIVE_CONTROL_1: s = cecaf_pkg::SLOT_RX_CTRL1;
			cecaf_pkg::OFF_RECEIVE_CONTROL_2: s = cecaf_pkg::SLOT_RX_CTRL2;
			cecaf_pkg::OFF_RECEIVE_CONTROL_3: s = cecaf_pkg::SLOT_RX_CTRL3;
			cecaf_pkg::OFF_TRANSMIT_ENABLE: s = cecaf_pkg::SLOT_TX_ENABLE;
			cecaf_pkg::OFF_TRANSMIT_BUFFER: s = cecaf_pkg::SLOT_TX_BUFFER;
			cecaf_pkg::OFF_TRANSMIT_CONTROL: s = cecaf_pkg::SLOT_TX_CTRL;
			default: s = cecaf_pkg::SLOT_NONE;
		endcase
		return s;
	endfunction

	// State
	logic [1:0] unit_enable_q;
	logic [1:0] unit_enable_d;
	logic [15:0] mask_q;
	logic [15:0] mask_d;
	logic [31:0] ctl_q [cecaf_pkg::NCTL];
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic run_q;
	logic run_d;
	logic srst_q;

	// Decode
	logic module_on;
	logic wr_unit_enable;
	logic wr_mask;
	logic wr_slot;
	logic srst_hit;
	logic [2:0] wr_slot_idx;
	logic [2:0] rd_slot_idx;
	logic [31:0] rd_word;
	logic [31:0] rd_ctl;

	assign module_on = unit_enable_q[cecaf_pkg::EN_MODULE_BIT];
	assign wr_unit_enable = reg_wr & (reg_addr == cecaf_pkg::OFF_UNIT_ENABLE);
	// R2 - gated writes while off
	assign wr_mask = reg_wr & module_on & (reg_addr == cecaf_pkg::OFF_LOGICAL_ADDRESS_MASK);
	assign wr_slot_idx = slot_of(reg_addr);
	assign wr_slot = reg_wr & module_on & (wr_slot_idx != cecaf_pkg::SLOT_NONE);
	// R10 - soft reset trigger
	assign srst_hit = reg_wr & module_on & (reg_addr == cecaf_pkg::OFF_SOFT_RESET)
		& reg_wdata[cecaf_pkg::SRST_BIT];

	// R5 - both bits in one write
	assign unit_enable_d = wr_unit_enable ? reg_wdata[1:0] : unit_enable_q;

	// R11 - upper bits dropped
	assign mask_d = srst_hit ? cecaf_pkg::MASK_RST : (wr_mask ? reg_wdata[15:0] : mask_q);

	// R4 - idle mode gating
	assign run_d = module_on & (~chip_idle | unit_enable_q[cecaf_pkg::EN_IDLE_BIT]);

	// R10 - enable register survives soft reset
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			unit_enable_q <= cecaf_pkg::UNIT_ENABLE_RST;
		end else begin
			unit_enable_q <= unit_enable_d;
		end
	end

	// R3 - mask held while disabled
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_q <= cecaf_pkg::MASK_RST;
		end else begin
			mask_q <= mask_d;
		end
	end

	// Plain control slots
	for (genvar i = 0; i < cecaf_pkg::NCTL; i++) begin : g_ctl
		logic [31:0] ctl_d;
		assign ctl_d = srst_hit ? cecaf_pkg::CTL_RST :
			((wr_slot && wr_slot_idx == 3'(i)) ? (reg_wdata & cecaf_pkg::CTL_WMASK[i]) : ctl_q[i]);
		always_ff @(posedge core_clk or negedge arst_n) begin
			if (!arst_n) begin
				ctl_q[i] <= cecaf_pkg::CTL_RST;
			end else begin
				ctl_q[i] <= ctl_d;
			end
		end
		assign cfg.ctl[i] = ctl_q[i];
	end

	// R9 - read decode
	assign rd_slot_idx = slot_of(reg_addr);
	assign rd_ctl = (rd_slot_idx == cecaf_pkg::SLOT_NONE) ? 32'h0000_0000 : ctl_q[rd_slot_idx];
	assign rd_word =
		(reg_addr == cecaf_pkg::OFF_UNIT_ENABLE) ? {30'h0, unit_enable_q} :
		(reg_addr == cecaf_pkg::OFF_LOGICAL_ADDRESS_MASK) ? {16'h0000, mask_q} :
		(reg_addr == cecaf_pkg::OFF_RECEIVE_ENABLE) ? {31'h0, eng_stat.rx_active} :
		(reg_addr == cecaf_pkg::OFF_RECEIVE_BUFFER) ? eng_stat.rx_buffer :
		(reg_addr == cecaf_pkg::OFF_RECEIVE_IRQ_STATUS) ? eng_stat.rx_status :
		(reg_addr == cecaf_pkg::OFF_TRANSMIT_IRQ_STATUS) ? eng_stat.tx_status :
		rd_ctl;
	assign rdata_d = reg_rd ? rd_word : 32'h0000_0000;

	// R1 - engines idle unless enabled
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			run_q <= 1'b0;
			srst_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			run_q <= run_d;
			srst_q <= srst_hit;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign run_en = run_q;
	assign soft_reset_pulse = srst_q;
	assign cfg.idle_mode_operation = unit_enable_q[cecaf_pkg::EN_IDLE_BIT];
	assign cfg.logical_address_mask = mask_q;

	// R6 - address match
	cecaf_addr_filter u_filter (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.run_en(run_q),
		.clear(srst_q),
		.mask(mask_q),
		.hdr(hdr),
		.match(match)
	);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	a_read_data_window: assert property ( // R9
		!reg_rd |=> reg_rdata == 32'h0000_0000
	) else $error("read data present without a read");

	a_enable_read_back: assert property ( // R5
		reg_wr && reg_addr == 8'h00 ##1 reg_rd && reg_addr == 8'h00
		|=> reg_rdata == {30'h0, $past(reg_wdata[1:0], 2)}
	) else $error("enable write does not read back");

	a_mask_upper_zero: assert property ( // R11
		reg_rd && reg_addr == 8'h04 |=> reg_rdata[31:16] == 16'h0000
	) else $error("mask upper bits not zero");

	a_enable_upper_zero: assert property ( // R11
		reg_rd && reg_addr == 8'h00 |=> reg_rdata[31:2] == 30'h0
	) else $error("enable upper bits not zero");

	a_mask_held_off: assert property ( // R3
		!unit_enable_q[0] && !(reg_wr && reg_addr == 8'h00) |=> $stable(mask_q) [*2]
	) else $error("mask changed while disabled");

	a_run_needs_enable: assert property ( // R1
		!unit_enable_q[0] |=> !run_en && !soft_reset_pulse ##1 !match.valid
	) else $error("controller active while disabled");

	a_idle_stops_run: assert property ( // R4
		unit_enable_q == 2'b01 && chip_idle |=> !run_en
	) else $error("controller runs in idle without idle enable");

	a_idle_keeps_run: assert property ( // R4
		unit_enable_q == 2'b11 |=> run_en
	) else $error("controller stopped although idle operation enabled");

	a_soft_reset_clears: assert property ( // R10
		srst_hit |=> mask_q == 16'h0000 && soft_reset_pulse && $stable(unit_enable_q)
	) else $error("soft reset did not clear mask or touched enable");

	a_off_write_ignored: assert property ( // R2
		!unit_enable_q[0] && reg_wr && reg_addr == 8'h14 |=> $stable(cfg.ctl[1])
	) else $error("control register written while disabled");

	// Write and hold paths
	a_enable_write_lands: assert property ( // R5
		reg_wr && reg_addr == cecaf_pkg::OFF_UNIT_ENABLE
		|=> unit_enable_q == $past(reg_wdata[1:0])
	) else $error("enable write did not land");

	a_enable_kept: assert property ( // R10
		!(reg_wr && reg_addr == cecaf_pkg::OFF_UNIT_ENABLE) |=> $stable(unit_enable_q)
	) else $error("enable register changed without a write");

	a_mask_write_lands: assert property ( // R6
		reg_wr && module_on && reg_addr == cecaf_pkg::OFF_LOGICAL_ADDRESS_MASK
		|=> mask_q == $past(reg_wdata[15:0])
	) else $error("mask write did not land");

	a_ctl_held_off: assert property ( // R3
		!module_on |=> $stable(cfg.ctl)
	) else $error("control registers changed while disabled");

	a_ctl_write_masked: assert property ( // R9
		reg_wr && module_on && reg_addr == cecaf_pkg::OFF_RECEIVE_CONTROL_1
		|=> cfg.ctl[1] == ($past(reg_wdata) & cecaf_pkg::CTL_WMASK[1])
	) else $error("receive control write not masked");

	a_ro_write_ignored: assert property ( // R9
		reg_wr && reg_addr == cecaf_pkg::OFF_RECEIVE_BUFFER
		|=> $stable(cfg.ctl) && $stable(mask_q)
	) else $error("write to read-only register changed state");

	a_srst_clears_ctl: assert property ( // R10
		srst_hit |=> cfg.ctl == '0
	) else $error("soft reset left control registers set");

	a_srst_bit0_only: assert property ( // R10
		reg_wr && reg_addr == cecaf_pkg::OFF_SOFT_RESET && !reg_wdata[0]
		|=> !soft_reset_pulse
	) else $error("soft reset fired without its bit");

	a_filter_cleared: assert property ( // R10
		soft_reset_pulse |=> !match.valid
	) else $error("match given during soft reset");

	a_filter_needs_run: assert property ( // R1
		!run_en |=> !match.valid
	) else $error("match given while engines stopped");

	a_run_when_awake: assert property ( // R4
		unit_enable_q[0] && !chip_idle |=> run_en
	) else $error("enabled controller not running");

	// Read path
	a_rd_enable_value: assert property ( // R9
		reg_rd && reg_addr == cecaf_pkg::OFF_UNIT_ENABLE
		|=> reg_rdata == {30'h0, $past(unit_enable_q)}
	) else $error("enable read value wrong");

	a_rd_mask_value: assert property ( // R6
		reg_rd && reg_addr == cecaf_pkg::OFF_LOGICAL_ADDRESS_MASK
		|=> reg_rdata == {16'h0000, $past(mask_q)}
	) else $error("mask read value wrong");

	a_rd_rx_active: assert property ( // R9
		reg_rd && reg_addr == cecaf_pkg::OFF_RECEIVE_ENABLE
		|=> reg_rdata == {31'h0, $past(eng_stat.rx_active)}
	) else $error("receive enable read value wrong");

	a_rd_rx_buffer: assert property ( // R9
		reg_rd && reg_addr == cecaf_pkg::OFF_RECEIVE_BUFFER
		|=> reg_rdata == $past(eng_stat.rx_buffer)
	) else $error("receive buffer read value wrong");

	a_rd_rx_status: assert property ( // R9
		reg_rd && reg_addr == cecaf_pkg::OFF_RECEIVE_IRQ_STATUS
		|=> reg_rdata == $past(eng_stat.rx_status)
	) else $error("receive status read value wrong");

	a_rd_tx_status: assert property ( // R9
		reg_rd && reg_addr == cecaf_pkg::OFF_TRANSMIT_IRQ_STATUS
		|=> reg_rdata == $past(eng_stat.tx_status)
	) else $error("transmit status read value wrong");

	a_rd_srst_zero: assert property ( // R9
		reg_rd && reg_addr == cecaf_pkg::OFF_SOFT_RESET
		|=> reg_rdata == 32'h0000_0000
	) else $error("soft reset register did not read zero");

	a_rd_unmapped_zero: assert property ( // R9
		reg_rd && reg_addr > cecaf_pkg::OFF_TRANSMIT_IRQ_STATUS
		|=> reg_rdata == 32'h0000_0000
	) else $error("unmapped offset did not read zero");

	a_rd_ctl_slot: assert property ( // R9
		reg_rd && reg_addr == cecaf_pkg::OFF_RECEIVE_CONTROL_1
		|=> reg_rdata == $past(cfg.ctl[1])
	) else $error("receive control read value wrong");

	c_enable_both: cover property (reg_wr && reg_addr == 8'h00 && reg_wdata[1:0] == 2'b11 ##1 1'b1);
	c_soft_reset: cover property (srst_hit ##1 soft_reset_pulse);
	c_idle_run: cover property (chip_idle && run_en);
	c_disable_keep: cover property (unit_enable_q[0] ##1 !unit_enable_q[0] && mask_q != 16'h0000);

endmodule

// [cecaf_bus_peer.sv]
// Model of the receive and transmit engines facing the register front end
`timescale 1ns/1ps
module cecaf_bus_peer (
	// Clock
	input wire logic core_clk,
	// Engine side
	output cecaf_pkg::cecaf_hdr_s hdr,
	output cecaf_pkg::cecaf_stat_s eng_stat
);
	initial begin
		hdr = '0;
		eng_stat = '{rx_active: 1'b1, rx_buffer: 32'h0000_03a5, rx_status: 32'h0000_0011,
			tx_status: 32'h0000_0022};
	end

	// One-cycle header; dest scrambled once released
	task automatic send(input logic [3:0] d);
		@(posedge core_clk);
		hdr.valid <= 1'b1;
		hdr.dest <= d;
		@(posedge core_clk);
		hdr.valid <= 1'b0;
		hdr.dest <= ~d;
	endtask
endmodule

// [test_cec_enable_and_address_filter.sv]
// Self-checking bench for the CEC register front end
`timescale 1ns/1ps
module test_cec_enable_and_address_filter;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic chip_idle = 1'b0;
	logic [31:0] reg_rdata;
	logic run_en;
	logic soft_reset_pulse;
	cecaf_pkg::cecaf_hdr_s hdr;
	cecaf_pkg::cecaf_stat_s eng_stat;
	cecaf_pkg::cecaf_cfg_s cfg;
	cecaf_pkg::cecaf_match_s match;
	int fails = 0;
	int checks_done = 0;
	logic [7:0] offs [7] = '{8'h0c, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28};
	logic [31:0] v;

	always #25 core_clk = ~core_clk;

	cecaf_top u_dut (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.chip_idle(chip_idle), .eng_stat(eng_stat), .hdr(hdr), .run_en(run_en),
		.soft_reset_pulse(soft_reset_pulse), .cfg(cfg), .match(match));

	cecaf_bus_peer u_peer (.core_clk(core_clk), .hdr(hdr), .eng_stat(eng_stat));

	task automatic finish_test();
		if (fails == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask

	// Write then read with no gap between strobes
	task automatic wr_rd_chk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask

	// Verdict expected for a header to address d under mask m
	function automatic logic [3:0] verdict(input logic [15:0] m, input logic [3:0] d);
		logic bc;
		bc = (d == 4'hf);
		return {1'b1, m[d] | bc, bc, (!bc & m[d]) | (bc & m[15])};
	endfunction

	task automatic hdr_chk(input logic [3:0] d, input logic [3:0] exp);
		u_peer.send(d);
		#1;
		check({28'h0, match}, {28'h0, exp});
	endtask

	initial begin
		#(50 * 3000);
		fails++;
		finish_test();
	end

	initial begin
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		#1;
		check({31'h0, run_en}, 32'h0);
		rd_chk(8'h00, 32'h0);
		rd_chk(8'h04, 32'h0);
		wr(8'h04, 32'h0000_00ff);
		rd_chk(8'h04, 32'h0);
		wr(8'h00, 32'hffff_ffff);
		@(posedge core_clk);
		#1;
		check({31'h0, run_en}, 32'h1);
		rd_chk(8'h00, 32'h3);
		check({31'h0, cfg.idle_mode_operation}, 32'h1);
		@(posedge core_clk);
		chip_idle <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		check({31'h0, run_en}, 32'h1);
		wr(8'h00, 32'h1);
		@(posedge core_clk);
		#1;
		check({31'h0, run_en}, 32'h0);
		@(posedge core_clk);
		chip_idle <= 1'b0;
		wr(8'h04, 32'hffff_1234);
		rd_chk(8'h04, 32'h0000_1234);
		check({16'h0, cfg.logical_address_mask}, 32'h0000_1234);
		for (int d = 0; d < 16; d++) begin
			hdr_chk(4'(d), verdict(16'h1234, 4'(d)));
		end
		wr(8'h04, 32'h0000_8001);
		hdr_chk(4'hf, verdict(16'h8001, 4'hf));
		hdr_chk(4'h0, verdict(16'h8001, 4'h0));
		// Every plain control slot, with its writable bits
		for (int i = 0; i < 7; i++) begin
			v = 32'h5a5a_a5a5 ^ 32'(i);
			wr(offs[i], v);
			check(cfg.ctl[i], v & cecaf_pkg::CTL_WMASK[i]);
			rd_chk(offs[i], (i == 0) ? 32'h1 : (v & cecaf_pkg::CTL_WMASK[i]));
		end
		wr(8'h10, 32'hffff_ffff);
		rd_chk(8'h10, 32'h0000_03a5);
		rd_chk(8'h2c, 32'h0000_0011);
		rd_chk(8'h30, 32'h0000_0022);
		rd_chk(8'h34, 32'h0);
		wr(8'h00, 32'h0);
		rd_chk(8'h04, 32'h0000_8001);
		check(cfg.ctl[6], 32'h5a5a_a5a3);
		wr(8'h04, 32'h0);
		rd_chk(8'h04, 32'h0000_8001);
		hdr_chk(4'h0, 4'h0);
		wr(8'h00, 32'h1);
		wr(8'h08, 32'h1);
		check({31'h0, soft_reset_pulse}, 32'h1);
		rd_chk(8'h04, 32'h0);
		rd_chk(8'h00, 32'h1);
		check(cfg.ctl[5], 32'h0);
		rd_chk(8'h08, 32'h0);
		wr_rd_chk(8'h00, 32'h3, 32'h3);
		finish_test();
	end
endmodule
